// ==== adcsc_pkg.sv ====
// shared constants for the dual channel converter serial control block
package adcsc_pkg;

    // ****************************************************************
    // conversion framing
    // ****************************************************************
    localparam int unsigned CONV_CLKS    = 16;
    localparam logic [3:0]  CNT_LAST     = 4'h0f;
    localparam logic [3:0]  CNT_WORD_END = 4'h07;
    localparam logic [3:0]  CNT_TRACK_N  = 4'h03;
    localparam logic [3:0]  CNT_MSB      = 4'h04;
    localparam logic [3:0]  CNT_LSB      = 4'h0b;
    localparam logic [3:0]  CNT_RST      = 4'h0;

    // ****************************************************************
    // channel_select_control word layout
    // ****************************************************************
    localparam int unsigned CTL_W          = 8;
    localparam int unsigned CHAN_SEL_BIT2  = 5;
    localparam int unsigned CHAN_SEL_BIT1  = 4;
    localparam int unsigned CHAN_SEL_BIT0  = 3;
    localparam logic [7:0]  CTL_RST        = 8'h00;

    // ****************************************************************
    // channel codes and reset values
    // ****************************************************************
    localparam logic        CHAN_INPUT_A   = 1'b0;
    localparam logic        CHAN_INPUT_B   = 1'b1;
    localparam logic        PD_RST         = 1'b1;
    localparam logic [7:0]  CODE_RST       = 8'h00;

    // ****************************************************************
    // host limit
    // ****************************************************************
    localparam int unsigned SCLK_MAX_HZ    = 8_000_000;

endpackage : adcsc_pkg

// ==== adcsc_top.sv ====
// serial control logic of the two channel 8-bit converter
`timescale 1ns/1ps

module adcsc_top
    import adcsc_pkg::*;
#(
    parameter int unsigned CODE_W = 8
) (
    // system clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // serial link
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              din,
    output logic                   dout,
    output logic                   dout_oe,
    // converter core
    input  wire logic [CODE_W-1:0] core_code,
    output logic                   mux_sel,
    output logic                   track_en,
    output logic                   power_up
);

    generate
        if (CODE_W != 8) begin : g_bad_width
            $error("adcsc_top serves an 8-bit result only");
        end
    endgenerate

    // ****************************************************************
    // link side, rising edges: frame counter and control word
    // ****************************************************************
    // select high acts as the async reset: the link clock is gated off
    // outside frames, so nothing here may wait for an edge to clear.
    logic [3:0]       cnt_q, cnt_d;
    logic [6:0]       sh_q, sh_d;
    logic [CTL_W-1:0] ctl_q, ctl_d;
    logic             wok_q, wok_d;

    always_comb begin
        cnt_d = 4'(cnt_q + 4'h1);
        sh_d  = sh_q;
        ctl_d = ctl_q;
        wok_d = wok_q;
        if (cnt_q <= CNT_WORD_END) begin
            sh_d = {sh_q[5:0], din};
        end
        if (cnt_q == CNT_WORD_END) begin
            ctl_d = {sh_q, din};
            wok_d = 1'b1;
        end else if (cnt_q == CNT_LAST) begin
            wok_d = 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= CNT_RST;
            sh_q  <= 7'h00;
            ctl_q <= CTL_RST;
            wok_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
            ctl_q <= ctl_d;
            wok_q <= wok_d;
        end
    end

    // ****************************************************************
    // link side, falling edges: track, power-down and data out
    // ****************************************************************
    logic [CODE_W-1:0] snap_q, snap_d;
    logic              trk_q, trk_d;
    logic              pd_q, pd_d;
    logic              dout_d;
    logic              oe_d;

    function automatic logic [2:0] bit_index(input logic [3:0] cnt);
        bit_index = 3'(CNT_LSB - cnt);
    endfunction : bit_index

    always_comb begin
        trk_d  = (cnt_q < CNT_TRACK_N);
        pd_d   = (cnt_q == CNT_LAST);
        oe_d   = 1'b1;
        dout_d = 1'b0;
        if (cnt_q >= CNT_MSB && cnt_q <= CNT_LSB) begin
            // snapshot is frozen since hold began one clock earlier
            dout_d = snap_q[bit_index(cnt_q)];
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            trk_q   <= 1'b0;
            pd_q    <= PD_RST;
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            trk_q   <= trk_d;
            pd_q    <= pd_d;
            dout    <= dout_d;
            dout_oe <= oe_d;
        end
    end

    // ****************************************************************
    // system side: synchronisers and channel / sample handling
    // ****************************************************************
    logic trk_s1_q, trk_s2_q, trk_s3_q;
    logic wok_s1_q, wok_s2_q, wok_s3_q;
    logic pd_s1_q, pd_s2_q;
    logic pend_q, pend_d;
    logic act_d, pwr_d, trk_out_d;

    always_comb begin
        pend_d    = pend_q;
        // ctl_q stays still for 8 link clocks after the word flag rises
        if (wok_s2_q && !wok_s3_q && !ctl_q[CHAN_SEL_BIT1]) begin
            pend_d = ctl_q[CHAN_SEL_BIT0];
        end
        act_d     = mux_sel;
        if (trk_s2_q && !trk_s3_q) begin
            act_d = pend_q;
        end
        // code is already quantised straight binary by the core
        snap_d    = trk_s2_q ? core_code : snap_q;
        pwr_d     = !pd_s2_q;
        trk_out_d = trk_s2_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trk_s1_q <= 1'b0;
            trk_s2_q <= 1'b0;
            trk_s3_q <= 1'b0;
            wok_s1_q <= 1'b0;
            wok_s2_q <= 1'b0;
            wok_s3_q <= 1'b0;
            pd_s1_q  <= PD_RST;
            pd_s2_q  <= PD_RST;
            pend_q   <= CHAN_INPUT_A;
            mux_sel  <= CHAN_INPUT_A;
            snap_q   <= CODE_RST;
            power_up <= 1'b0;
            track_en <= 1'b0;
        end else begin
            trk_s1_q <= trk_q;
            trk_s2_q <= trk_s1_q;
            trk_s3_q <= trk_s2_q;
            wok_s1_q <= wok_q;
            wok_s2_q <= wok_s1_q;
            wok_s3_q <= wok_s2_q;
            pd_s1_q  <= pd_q;
            pd_s2_q  <= pd_s1_q;
            pend_q   <= pend_d;
            mux_sel  <= act_d;
            snap_q   <= snap_d;
            power_up <= pwr_d;
            track_en <= trk_out_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    cnt_wrap_a : assert property (
        @(posedge sclk) disable iff (cs_n)
        (cnt_q == CNT_LAST) |=> (cnt_q == CNT_RST))
        else $error("frame counter did not wrap after 16 clocks");

    word_take_a : assert property (
        @(posedge sclk) disable iff (cs_n)
        (cnt_q == CNT_WORD_END) |=> (ctl_q == {$past(sh_q), $past(din)}))
        else $error("control word not taken on 8th rising edge");

    track_span_a : assert property (
        @(negedge sclk) disable iff (cs_n)
        (cnt_q == CNT_RST) |=> trk_q ##3 !trk_q)
        else $error("track window not three clocks long");

    zero_fill_a : assert property (
        @(negedge sclk) disable iff (cs_n)
        (cnt_q < CNT_MSB || cnt_q > CNT_LSB) |=> !dout)
        else $error("non result clock carried a one");

    msb_first_a : assert property (
        @(negedge sclk) disable iff (cs_n)
        (cnt_q == CNT_MSB) |=> (dout == snap_q[7]) && dout_oe)
        else $error("result msb not sent on the 5th clock");

    auto_pd_a : assert property (
        @(negedge sclk) disable iff (cs_n)
        (cnt_q == CNT_LAST) |=> pd_q ##1 !pd_q)
        else $error("auto power-down window wrong");

    chan_next_a : assert property (
        @(posedge clk) disable iff (!rst_n)
        (trk_s2_q && !trk_s3_q) |=> (mux_sel == $past(pend_q)))
        else $error("channel not applied at next track start");

    chan_pick_a : assert property (
        @(posedge clk) disable iff (!rst_n)
        (wok_s2_q && !wok_s3_q && !ctl_q[CHAN_SEL_BIT1])
        |=> (pend_q == $past(ctl_q[CHAN_SEL_BIT0])))
        else $error("channel field decoded wrongly");

    power_follow_a : assert property (
        @(posedge clk) disable iff (!rst_n)
        pd_s2_q |=> !power_up)
        else $error("powered while link asks power-down");

endmodule : adcsc_top

// ==== adcsc_host_model.sv ====
// host serial master model driving the converter link
`timescale 1ns/1ps

module adcsc_host_model #(
    parameter realtime HALF = 62.5
) (
    // link to the converter
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    // a released output reads as z so a missing drive never matches
    wire line = dout_oe ? dout : 1'bz;

    initial begin
        sclk = 1'b1; // parked high between frames
        cs_n = 1'b0;
        din  = 1'b0;
        // select rises after time zero so the link reset is never missed
        #1 cs_n = 1'b1;
    end

    task automatic select(input logic lvl);
        #HALF cs_n = lvl;
    endtask : select

    // ****************************************************************
    // one conversion: word on rising 1..8, result sampled on rising
    // ****************************************************************
    task automatic conv(input logic [7:0] w, output logic [15:0] r);
        for (int i = 1; i <= 16; i++) begin
            #HALF sclk = 1'b0;
            din = (i <= 8) ? w[8-i] : ~din;
            #HALF sclk = 1'b1;
            r[16-i] = line;
        end
    endtask : conv

    // cut conversion: only n clocks (n up to 8), clock parked high after
    task automatic part(input logic [7:0] w, input int n);
        for (int i = 1; i <= n; i++) begin
            #HALF sclk = 1'b0;
            din = w[8-i];
            #HALF sclk = 1'b1;
        end
    endtask : part
endmodule : adcsc_host_model

// ==== tb_top.sv ====
// self-checking bench for the converter serial control block
`timescale 1ns/1ps

module tb_top;
    import adcsc_pkg::*;

    logic        clk;
    logic        rst_n;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic [7:0]  core_code;
    logic        mux_sel;
    logic        track_en;
    logic        power_up;
    logic [15:0] r;
    int          bad_count;
    int          check_count;

    // ****************************************************************
    // conversion table
    // ****************************************************************
    // words never set field bit 1; ignored bits toggled on purpose
    localparam logic [7:0] WORDS [6] = '{8'h08, 8'hc7, 8'hcf, 8'h20,
                                         8'h28, 8'h00};
    localparam logic [7:0] CODES [6] = '{8'h00, 8'hff, 8'h5a, 8'ha5,
                                         8'h01, 8'h80};
    localparam logic       CHANS [6] = '{CHAN_INPUT_A, CHAN_INPUT_B,
                                         CHAN_INPUT_A, CHAN_INPUT_B,
                                         CHAN_INPUT_A, CHAN_INPUT_B};

    initial clk = 1'b0;
    always #4 clk = ~clk;

    adcsc_top dut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .core_code(core_code),
        .mux_sel(mux_sel), .track_en(track_en), .power_up(power_up)
    );

    adcsc_host_model host (
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe)
    );

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // word k names the channel of conversion k+1, not of conversion k
    task automatic one_conv(input int k);
        fork
            host.conv(WORDS[k], r);
            begin
                @(posedge clk);
                #1 core_code = CODES[k];
                repeat (20) @(posedge clk);
                #1;
                check("track_en", 16'(track_en), 16'h0001);
                repeat (80) @(posedge clk);
                #1;
                check("track_en", 16'(track_en), 16'h0000);
                check("power_up", 16'(power_up), 16'h0001);
                check("mux_sel", 16'(mux_sel),
                      16'(CHANS[k]));
            end
        join
        check("dout", r,
              {4'h0, CODES[k], 4'h0});
        check("power_up", 16'(power_up), 16'h0000);
    endtask : one_conv

    initial begin
        rst_n       = 1'b0;
        core_code   = 8'h00;
        bad_count   = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        check("mux_sel", 16'(mux_sel), 16'h0000);
        check("dout_oe", 16'(dout_oe), 16'h0000);
        host.select(1'b0);
        for (int k = 0; k < 6; k++) begin
            if (k == 3) begin
                host.select(1'b1);
                repeat (10) @(posedge clk);
                #1;
                check("dout_oe", 16'(dout_oe), 16'h0000);
                check("power_up", 16'(power_up), 16'h0000);
                $display("test back to back frame done");
                host.select(1'b0);
            end
            one_conv(k);
        end
        host.select(1'b1);
        $display("test second frame done");
        // frame cut after 6 clocks: powered until select rises, word lost
        host.select(1'b0);
        host.part(WORDS[0], 6);
        check("power_up", 16'(power_up), 16'h0001);
        host.select(1'b1);
        repeat (5) @(posedge clk);
        #1;
        check("power_up", 16'(power_up), 16'h0000);
        check("dout_oe", 16'(dout_oe), 16'h0000);
        host.select(1'b0);
        // cut word never landed, so input a set by word 5 still applies
        one_conv(0);
        host.select(1'b1);
        $display("test cut frame done");
        complete_run();
    end

    // a full run takes about 15.4 us
    initial begin
        #50_000;
        bad_count++;
        complete_run();
    end
endmodule : tb_top
